// >>> include/dis_pkg.sv
// constants and types for the diagnostic interrupt section framer
package dis_pkg;

  // ----------------------------------------
  // section geometry
  // ----------------------------------------
  localparam int unsigned SEC_MAX = 48;
  localparam int unsigned HDR_LEN = 4;
  localparam int unsigned DIAG_INFO_MAX = 44;
  localparam int unsigned HW_INFO_LEN = 4;
  localparam int unsigned RI_INFO_LEN = 5;
  localparam int unsigned UPD_INFO_LEN = 2;
  localparam int unsigned SELF_INFO_SIMPLEX = 16;
  localparam int unsigned SELF_INFO_REDUNDANT = 24;

  // ----------------------------------------
  // byte offsets from the section start
  // ----------------------------------------
  localparam int unsigned OFS_LEN = 0;
  localparam int unsigned OFS_HDR1 = 1;
  localparam int unsigned OFS_INFO = 4;
  localparam int unsigned OFS_REC1 = 8;
  localparam int unsigned OFS_BITS = 9;
  localparam int unsigned OFS_NCH = 10;
  localparam int unsigned OFS_EVT = 11;
  localparam int unsigned OFS_MAP0 = 12;
  localparam int unsigned OFS_MAP1 = 20;
  localparam int unsigned MAP_BYTES = 8;

  // ----------------------------------------
  // field values and positions
  // ----------------------------------------
  localparam logic [7:0] SELF_DIAG_ID = 8'h55;
  localparam int unsigned EVT_CH0_BIT = 0;
  localparam int unsigned EVT_CH1_BIT = 1;
  localparam int unsigned SUPPLY1_BIT = 0;
  localparam int unsigned SUPPLY2_BIT = 1;
  localparam logic [15:0] UPD_PARAM_RESET = 16'h0000;
  localparam logic [7:0] FRAME_MAX_DEFAULT = 8'hF4;

  // ----------------------------------------
  // buffering
  // ----------------------------------------
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_WIDTH = 9;

  typedef enum logic [1:0] {
    KIND_DIAG,
    KIND_HW,
    KIND_REMINS,
    KIND_UPDATE
  } dis_kind_t;

endpackage : dis_pkg

// >>> logic/dis_fifo.sv
// synchronous valid/ready fifo for the outgoing byte stream
`timescale 1ns/1ps
`default_nettype none

module dis_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk, // clock
  input wire logic rst, // synchronous reset, active high
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // read accept
  output logic [WIDTH-1:0] out_data // head word
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      if (push && !pop)
      begin
        count <= count + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count <= count - (AW+1)'(1);
      end
    end
  end

endmodule : dis_fifo

`default_nettype wire

// >>> logic/dis_framer.sv
// interrupt section framer for slave diagnostic frames
`timescale 1ns/1ps
`default_nettype none

module dis_framer #(
  parameter int unsigned DEPTH = dis_pkg::FIFO_DEPTH,
  parameter logic [7:0] FRAME_MAX = dis_pkg::FRAME_MAX_DEFAULT
) (
  input wire logic CLK, // clock, 250 MHz
  input wire logic RST, // synchronous reset, active high
  input wire logic START, // pulse: build one section
  input wire logic [1:0] KIND, // interrupt kind of the request
  input wire logic [23:0] HDR, // header bytes 1..3, byte 1 in low bits
  input wire logic [31:0] REC0, // diagnostic record zero, byte 4 in low bits
  input wire logic [31:0] HW_INFO, // hardware info, byte 4 in low bits
  input wire logic [39:0] RI_INFO, // remove/insert info, byte 4 in low bits
  input wire logic SELF_DIAG, // diagnostic raised by the interface module
  input wire logic [35*8-1:0] REC1_EXT, // record one bytes 9..43 for other sources
  input wire logic [5:0] REC1_EXT_LEN, // length of record one for other sources
  input wire logic [7:0] REC1_EXT_ID, // byte 8 for other sources
  input wire logic [7:0] CH_BITS, // bit length of each channel entry
  input wire logic [7:0] CH_COUNT, // channels per module
  input wire logic REDUNDANT, // interface module runs redundant
  input wire logic [63:0] MAP0, // channel-zero error types
  input wire logic [63:0] MAP1, // channel-one error types
  input wire logic SUPPLY1_FAULT, // first supply fault
  input wire logic SUPPLY2_FAULT, // second supply fault
  input wire logic PARAM_WR, // pulse: parameter set received
  input wire logic [15:0] PARAM_DATA, // received parameter set
  input wire logic PARAM_FAULTY, // received set is faulty
  input wire logic [7:0] CHAN_START, // byte where channel diagnostics begin
  input wire logic [7:0] CHAN_LEN, // bytes of channel diagnostics wanted
  output logic BUSY, // section being built
  output logic [15:0] PARAM_ACTIVE, // currently valid parameters
  output logic UPD_PENDING, // update interrupt waiting
  output logic [7:0] CHAN_KEEP, // channel bytes left after shortening
  output logic [7:0] SEC_START, // byte where the section starts
  output logic [5:0] SEC_LEN, // length of the section last built
  output logic OUT_VALID, // stream byte valid
  input wire logic OUT_READY, // stream byte accepted
  output logic [7:0] OUT_DATA, // stream byte
  output logic OUT_LAST // last byte of the section
);

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SEND
  } dis_state_t;

  dis_state_t state;
  logic [7:0] sec_buf [0:dis_pkg::SEC_MAX-1];
  logic [5:0] idx;
  logic [5:0] len;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [8:0] fifo_in_data;
  logic [8:0] fifo_out_data;
  logic launch;
  logic launch_upd;
  logic param_ok;
  logic [1:0] kind_eff;
  logic [63:0] map0_eff;
  logic [5:0] next_len;
  logic [8:0] room;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] sec_length(input logic [1:0] kind, input logic self_diag,
                                           input logic red, input logic [5:0] ext_len);
    logic [5:0] info;
    info = 6'(dis_pkg::HW_INFO_LEN);
    case (kind)
      dis_pkg::KIND_DIAG:
      begin
        if (self_diag)
        begin
          info = red ? 6'(dis_pkg::SELF_INFO_REDUNDANT)
                     : 6'(dis_pkg::SELF_INFO_SIMPLEX);
        end
        else
        begin
          info = 6'(4) + ((ext_len > 6'(36)) ? 6'(36) : ext_len);
        end
      end
      dis_pkg::KIND_HW: info = 6'(dis_pkg::HW_INFO_LEN);
      dis_pkg::KIND_REMINS: info = 6'(dis_pkg::RI_INFO_LEN);
      default: info = 6'(dis_pkg::UPD_INFO_LEN);
    endcase
    return 6'(dis_pkg::HDR_LEN) + info;
  endfunction : sec_length

  function automatic logic [7:0] map_byte(input logic [63:0] map, input int unsigned k);
    return map[8*k +: 8];
  endfunction : map_byte

  // ----------------------------------------
  // request arbitration
  // ----------------------------------------
  assign param_ok = PARAM_WR && !PARAM_FAULTY;
  assign launch = (state == ST_IDLE) && (START || UPD_PENDING);
  assign kind_eff = START ? KIND : 2'(dis_pkg::KIND_UPDATE);
  assign launch_upd = launch && (kind_eff == 2'(dis_pkg::KIND_UPDATE));
  assign next_len = sec_length(kind_eff, SELF_DIAG, REDUNDANT, REC1_EXT_LEN);
  assign room = 9'(FRAME_MAX) - 9'(CHAN_START) - 9'(next_len);

  always_comb
  begin
    map0_eff = MAP0;
    map0_eff[dis_pkg::SUPPLY1_BIT] = MAP0[dis_pkg::SUPPLY1_BIT] | SUPPLY1_FAULT;
    map0_eff[dis_pkg::SUPPLY2_BIT] = MAP0[dis_pkg::SUPPLY2_BIT] | SUPPLY2_FAULT;
  end

  // ----------------------------------------
  // parameter set and update request
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PARAM_ACTIVE <= dis_pkg::UPD_PARAM_RESET;
    end
    else if (param_ok)
    begin
      PARAM_ACTIVE <= PARAM_DATA;
    end
  end

  // a new valid set wins over the clear by a launching update
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      UPD_PENDING <= 1'b0;
    end
    else
    begin
      UPD_PENDING <= (UPD_PENDING && !launch_upd) || param_ok;
    end
  end

  // ----------------------------------------
  // placement in the diagnostic frame
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      CHAN_KEEP <= 8'h00;
      SEC_START <= 8'h00;
      SEC_LEN <= 6'h00;
    end
    else if (launch)
    begin
      SEC_LEN <= next_len;
      if (room[8])
      begin
        CHAN_KEEP <= 8'h00;
        SEC_START <= CHAN_START;
      end
      else if (9'(CHAN_LEN) > room)
      begin
        CHAN_KEEP <= room[7:0];
        SEC_START <= CHAN_START + room[7:0];
      end
      else
      begin
        CHAN_KEEP <= CHAN_LEN;
        SEC_START <= CHAN_START + CHAN_LEN;
      end
    end
  end

  // ----------------------------------------
  // section image
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (launch)
    begin
      for (int i = 0; i < dis_pkg::SEC_MAX; i++)
      begin
        sec_buf[i] <= 8'h00;
      end
      sec_buf[dis_pkg::OFS_LEN] <= {2'b00, next_len};
      for (int i = 0; i < 3; i++)
      begin
        sec_buf[dis_pkg::OFS_HDR1 + i] <= HDR[8*i +: 8];
      end
      case (kind_eff)
        dis_pkg::KIND_DIAG:
        begin
          for (int i = 0; i < 4; i++)
          begin
            sec_buf[dis_pkg::OFS_INFO + i] <= REC0[8*i +: 8];
          end
          if (SELF_DIAG)
          begin
            sec_buf[dis_pkg::OFS_REC1] <= dis_pkg::SELF_DIAG_ID;
            sec_buf[dis_pkg::OFS_BITS] <= CH_BITS;
            sec_buf[dis_pkg::OFS_NCH] <= CH_COUNT;
            sec_buf[dis_pkg::OFS_EVT] <= {6'h00, REDUNDANT && (MAP1 != 64'h0),
                                          map0_eff != 64'h0};
            for (int k = 0; k < dis_pkg::MAP_BYTES; k++)
            begin
              sec_buf[dis_pkg::OFS_MAP0 + k] <= map_byte(map0_eff, k);
              if (REDUNDANT)
              begin
                sec_buf[dis_pkg::OFS_MAP1 + k] <= map_byte(MAP1, k);
              end
            end
          end
          else
          begin
            sec_buf[dis_pkg::OFS_REC1] <= REC1_EXT_ID;
            for (int i = 0; i < 35; i++)
            begin
              sec_buf[dis_pkg::OFS_BITS + i] <= REC1_EXT[8*i +: 8];
            end
          end
        end
        dis_pkg::KIND_HW:
        begin
          for (int i = 0; i < dis_pkg::HW_INFO_LEN; i++)
          begin
            sec_buf[dis_pkg::OFS_INFO + i] <= HW_INFO[8*i +: 8];
          end
        end
        dis_pkg::KIND_REMINS:
        begin
          for (int i = 0; i < dis_pkg::RI_INFO_LEN; i++)
          begin
            sec_buf[dis_pkg::OFS_INFO + i] <= RI_INFO[8*i +: 8];
          end
        end
        default:
        begin
          sec_buf[dis_pkg::OFS_INFO] <= PARAM_ACTIVE[7:0];
          sec_buf[dis_pkg::OFS_INFO + 1] <= PARAM_ACTIVE[15:8];
        end
      endcase
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      idx <= 6'h00;
      len <= 6'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (launch)
          begin
            state <= ST_SEND;
            idx <= 6'h00;
            len <= next_len;
          end
        end
        ST_SEND:
        begin
          if (fifo_in_ready)
          begin
            if (idx == len - 6'h01)
            begin
              state <= ST_IDLE;
            end
            idx <= idx + 6'h01;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign BUSY = (state == ST_SEND);
  assign fifo_in_valid = (state == ST_SEND);
  assign fifo_in_data = {idx == len - 6'h01, sec_buf[idx]};

  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  dis_fifo #(
    .WIDTH(dis_pkg::FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(fifo_out_data)
  );

  assign OUT_DATA = fifo_out_data[7:0];
  assign OUT_LAST = fifo_out_data[8];

endmodule : dis_framer

`default_nettype wire

// >>> verif/dis_chk.sv
// port checker for the interrupt section framer
`timescale 1ns/1ps
`default_nettype none

module dis_chk #(
  parameter int unsigned DEPTH = 32
) (
  input wire logic CLK, // clock
  input wire logic RST, // reset
  input wire logic START, // launch request
  input wire logic [1:0] KIND, // interrupt kind
  input wire logic SELF_DIAG, // self layout
  input wire logic REDUNDANT, // redundant module
  input wire logic PARAM_WR, // parameter strobe
  input wire logic [15:0] PARAM_DATA, // parameter value
  input wire logic PARAM_FAULTY, // faulty set
  input wire logic BUSY, // building
  input wire logic [15:0] PARAM_ACTIVE, // valid set
  input wire logic UPD_PENDING, // update waiting
  input wire logic [5:0] SEC_LEN, // section length
  input wire logic OUT_VALID, // stream valid
  input wire logic OUT_READY, // stream ready
  input wire logic [7:0] OUT_DATA, // stream byte
  input wire logic OUT_LAST // final byte
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  launch_busy_a: assert property (START && !BUSY |=> BUSY)
    else $error("busy missing after start");
  hw_len_a: assert property (START && !BUSY && KIND == 2'h1 |=> SEC_LEN == 6'h08)
    else $error("hardware length wrong");
  remins_len_a: assert property (START && !BUSY && KIND == 2'h2 |=> SEC_LEN == 6'h09)
    else $error("remove insert length wrong");
  upd_len_a: assert property (UPD_PENDING && !BUSY && !START |=> BUSY && SEC_LEN == 6'h06)
    else $error("update launch wrong");
  busy_span_a: assert property ($rose(BUSY) |-> BUSY [*6])
    else $error("busy too short");
  len_cap_a: assert property (START && !BUSY && KIND == 2'h0 |=> SEC_LEN <= 6'h30)
    else $error("section over cap");
  self_len_a: assert property (START && !BUSY && KIND == 2'h0 && SELF_DIAG |=>
    SEC_LEN == ($past(REDUNDANT) ? 6'h1C : 6'h14)) else $error("self length wrong");
  hold_a: assert property (OUT_VALID && !OUT_READY |=>
    OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST)) else $error("stream not held");
  faulty_keep_a: assert property (PARAM_WR && PARAM_FAULTY |=> $stable(PARAM_ACTIVE))
    else $error("faulty set taken");
  no_upd_a: assert property (PARAM_WR && PARAM_FAULTY && !UPD_PENDING |=> !UPD_PENDING)
    else $error("update after faulty set");
  param_take_a: assert property (PARAM_WR && !PARAM_FAULTY |=>
    UPD_PENDING && PARAM_ACTIVE == $past(PARAM_DATA)) else $error("good set not taken");
endmodule : dis_chk
`default_nettype wire

// >>> verif/dis_reader.sv
// byte stream reader standing in for the diagnostic master
`timescale 1ns/1ps
`default_nettype none

module dis_reader (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [1:0] mode, // 0 prompt, 1 random stalls, 2 stalled
  output var logic ready // byte accept
);
  always @(posedge clk)
  begin
    ready <= #1 !rst && (mode == 2'h0 || (mode == 2'h1 && $urandom % 3 != 0));
  end
endmodule : dis_reader
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the interrupt section framer
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end

module tb;
  logic CLK, RST, START, SELF_DIAG, REDUNDANT, SUPPLY1_FAULT, SUPPLY2_FAULT;
  logic PARAM_WR, PARAM_FAULTY, OUT_READY, BUSY, UPD_PENDING, OUT_VALID, OUT_LAST;
  logic [1:0] KIND, mode;
  logic [23:0] HDR;
  logic [31:0] REC0, HW_INFO;
  logic [39:0] RI_INFO;
  logic [279:0] REC1_EXT;
  logic [5:0] REC1_EXT_LEN, SEC_LEN;
  logic [7:0] REC1_EXT_ID, CH_BITS, CH_COUNT, CHAN_START, CHAN_LEN;
  logic [7:0] CHAN_KEEP, SEC_START, OUT_DATA;
  logic [63:0] MAP0, MAP1;
  logic [15:0] PARAM_DATA, PARAM_ACTIVE, pa;
  logic [8:0] q[$];
  logic [8:0] e;
  int err_total, num_checks;

  dis_framer dis_framer_inst (.*);
  dis_reader dis_reader_inst (.clk(CLK), .rst(RST), .mode(mode), .ready(OUT_READY));

  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  // ----------------------------------------
  // expected byte queue and helpers
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick

  task pb(input logic [7:0] v);
    q.push_back({1'b0, v});
  endtask : pb

  task pw(input logic [319:0] v, input int n);
    for (int j = 0; j < n; j++)
      pb(v[8*j +: 8]);
  endtask : pw

  task end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task idle(input logic d);
    int i;
    i = 0;
    while (i < 3000 && (BUSY !== 1'b0 || (d && OUT_VALID !== 1'b0)))
    begin
      tick(1);
      i++;
    end
    if (i == 3000)
    begin
      `CHK("timeout", 1'b0, 1'b1)
      end_sim();
    end
  endtask : idle

  task sect(input logic [1:0] k, input logic s, input logic r);
    int l, n, t;
    logic [63:0] m0;
    idle(1'b0);
    {HDR, REC0, HW_INFO, RI_INFO} = {$urandom, $urandom, $urandom, $urandom};
    {REC1_EXT_ID, CH_BITS, CH_COUNT, CHAN_START, CHAN_LEN} = {$urandom, 8'($urandom)};
    for (int j = 0; j < 35; j++)
      REC1_EXT[8*j +: 8] = 8'($urandom);
    MAP0 = $urandom % 2 ? {$urandom, $urandom} : 64'h0;
    MAP1 = $urandom % 2 ? {$urandom, $urandom} : 64'h0;
    {SUPPLY1_FAULT, SUPPLY2_FAULT} = 2'($urandom);
    REC1_EXT_LEN = 6'(1 + $urandom % 63);
    KIND = k;
    SELF_DIAG = s;
    REDUNDANT = r;
    START = 1'b1;
    n = REC1_EXT_LEN > 36 ? 36 : REC1_EXT_LEN;
    l = k == 3 ? 6 : k == 1 ? 8 : k == 2 ? 9 : s ? (r ? 28 : 20) : 8 + n;
    m0 = MAP0 | {62'h0, SUPPLY2_FAULT, SUPPLY1_FAULT};
    pb(8'(l));
    pw(HDR, 3);
    if (k == 1)
      pw(HW_INFO, 4);
    if (k == 2)
      pw(RI_INFO, 5);
    if (k == 3)
      pw(pa, 2);
    if (k == 0)
      pw(REC0, 4);
    if (k == 0 && !s)
      pb(REC1_EXT_ID);
    if (k == 0 && !s)
      pw(REC1_EXT, n - 1);
    if (k == 0 && s)
      pw({m0, 6'h0, r && MAP1 != 0, m0 != 0, CH_COUNT, CH_BITS, dis_pkg::SELF_DIAG_ID}, 12);
    if (k == 0 && s && r)
      pw(MAP1, 8);
    q[q.size()-1][8] = 1'b1;
    tick(1);
    START = 1'b0;
    tick(1);
    START = 1'b1;
    tick(1);
    START = 1'b0;
    t = dis_pkg::FRAME_MAX_DEFAULT - CHAN_START - l;
    t = t < 0 ? 0 : t < CHAN_LEN ? t : CHAN_LEN;
    `CHK("keep", 8'(t), CHAN_KEEP)
    `CHK("start", 8'(CHAN_START + t), SEC_START)
    `CHK("len", 6'(l), SEC_LEN)
  endtask : sect

  task upd(input logic f);
    idle(1'b0);
    PARAM_WR = 1'b1;
    PARAM_DATA = 16'($urandom);
    PARAM_FAULTY = f;
    if (!f)
      pa = PARAM_DATA;
    if (!f)
      pb(8'h06);
    if (!f)
      pw({pa, HDR}, 5);
    if (!f)
      q[q.size()-1][8] = 1'b1;
    tick(1);
    PARAM_WR = 1'b0;
    tick(2);
    `CHK("param", pa, PARAM_ACTIVE)
    `CHK("pend", 1'b0, UPD_PENDING)
  endtask : upd

  // ----------------------------------------
  // stream monitor and main sequence
  // ----------------------------------------
  always @(posedge CLK)
  begin
    if (!RST && OUT_VALID === 1'b1 && OUT_READY === 1'b1)
    begin
      e = q.size() ? q.pop_front() : 9'bx;
      `CHK("byte", e, {OUT_LAST, OUT_DATA})
    end
  end

  initial
  begin
    void'($urandom(79703));
    {START, KIND, SELF_DIAG, REDUNDANT, SUPPLY1_FAULT, SUPPLY2_FAULT, PARAM_WR} = '0;
    {HDR, REC0, HW_INFO, RI_INFO, REC1_EXT, REC1_EXT_LEN, REC1_EXT_ID, PARAM_FAULTY} = '0;
    {CH_BITS, CH_COUNT, MAP0, MAP1, PARAM_DATA, CHAN_START, CHAN_LEN, pa} = '0;
    RST = 1'b1;
    mode = 2'h0;
    tick(10);
    RST = 1'b0;
    mode = 2'h1;
    for (int i = 0; i < 16; i++)
      sect(2'(i % 3), i[2], i[3]);
    upd(1'b0);
    upd(1'b1);
    upd(1'b0);
    sect(2'h3, 1'b0, 1'b0);
    idle(1'b1);
    mode = 2'h2;
    repeat (5) sect(2'h1, 1'b0, 1'b0);
    tick(20);
    `CHK("stall", 2'h3, {BUSY, OUT_VALID})
    mode = 2'h0;
    idle(1'b1);
    `CHK("left", 0, q.size())
    end_sim();
  end
endmodule : tb

bind dis_framer dis_chk #(.DEPTH(DEPTH)) dis_chk_inst (.*);
`default_nettype wire
